// ### rtl/wsfp_fetch_path.v
// wavetable sample fetch path: address generator, fetch buffer, sample processor
// Notes on behaviour
// - fetch commands become bus-master read requests
// - read data fills the input sample buffer
// - full block signals processor to start
// - processor reports block clear when done
// - per-voice parameter set loaded by firmware
// - start command begins fetching that voice
// - voice address loops without firmware help
// - stop command ends further fetches of voice; a block in flight is finished
// - fetched samples written into input buffer
// - processor resamples or pitch-shifts samples
// - firmware-programmed pitch ratio is applied
// - processed samples written to dsp memory
// - all sample data comes over bus master
// - serves up to 64 voices and streams
`timescale 1ns/1ns
`include "wsfp_map.vh"
module wsfp_fetch_path
#(
  parameter VOICES = 64,
  parameter VBITS = 6,
  parameter AW = 32,
  parameter BLK = 16,
  parameter BBITS = 4,
  parameter DW = 16,
  parameter MW = 16
)
(
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // firmware voice command port
  input wire [1:0] cmd_in,
  input wire [VBITS-1:0] cmd_voice_in,
  input wire cmd_kind_in,
  input wire [AW-1:0] cmd_start_in,
  input wire [AW-1:0] cmd_loop_in,
  input wire [AW-1:0] cmd_end_in,
  input wire [15:0] cmd_ratio_in,
  input wire [MW-1:0] cmd_dest_in,
  // bus-master read request
  output wire rd_req_out,
  output reg [AW-1:0] rd_addr_out,
  output reg [BBITS:0] rd_len_out,
  input wire rd_gnt_in,
  // bus-master read data
  input wire rd_valid_in,
  input wire [DW-1:0] rd_data_in,
  // dsp data memory write
  output reg mem_we_out,
  output reg [MW-1:0] mem_addr_out,
  output reg [DW-1:0] mem_data_out,
  // status
  output wire [VOICES-1:0] voice_active_out,
  output wire busy_out
);
  // phase accumulator width: block index, fraction and room for one ratio step
  // a full 16-bit ratio step past the block end must not wrap the phase
  localparam PW = (BBITS + `WSFP_FRAC_BITS >= 16) ? BBITS + `WSFP_FRAC_BITS + 2 : 17;
  // bytes covered by one block of 16-bit words
  localparam [AW-1:0] BLK_BYTES = BLK * 2;

  // per-voice parameter tables
  // written by firmware load commands, read by the fetch sequencer and the sample processor
  // the current address table is also advanced by the sequencer
  reg [AW-1:0] v_addr [0:VOICES-1]; // next fetch byte address
  reg [AW-1:0] v_loop [0:VOICES-1]; // address to wrap back to
  reg [AW-1:0] v_end [0:VOICES-1]; // address that triggers the wrap
  reg [15:0] v_ratio [0:VOICES-1]; // 8.8 pitch step
  reg [MW-1:0] v_dest [0:VOICES-1]; // dsp memory block base
  reg v_kind [0:VOICES-1]; // stream or wavetable, stored only
  reg [VOICES-1:0] active; // voice is fetching

  // round-robin pointer and pick
  // the pointer moves one past each voice served, so no voice starves
  reg [VBITS-1:0] rr; // first voice to look at
  reg [VBITS-1:0] pick; // chosen voice this cycle
  reg [VBITS-1:0] cand; // voice under test in the search
  reg pick_ok; // some voice is active

  // fetch buffer state
  // one block buffer only: a new fetch waits for the clear pulse
  reg [1:0] fb_state; // fetch sequencer state
  reg [VBITS-1:0] cur; // voice owning the buffer
  reg [BBITS:0] fill; // words received so far
  reg [DW-1:0] buf_mem [0:BLK-1]; // input sample buffer
  reg blk_ready; // block handed to processor

  // processor state
  // the phase walks the block in 8.8 steps; its top bits flag the end
  reg sp_state; // idle or running
  reg [PW-1:0] phase; // read position in the block
  reg [15:0] ratio; // step latched at block start
  reg [MW-1:0] dest; // next dsp memory word
  reg blk_clear; // one-cycle clear pulse
  integer k; // search loop index
  wire [AW-1:0] blk_bytes; // address step per block
  assign blk_bytes = BLK_BYTES;

  // round-robin search from the pointer for an active voice
  // the sum wraps at the index width, so the voice count must be a power of two
  // the loop runs downwards so the nearest active voice at or after the pointer wins
  always @*
  begin
    pick = rr;
    pick_ok = 1'b0;
    cand = rr;
    for (k = VOICES - 1; k >= 0; k = k - 1)
    begin
      // candidate voice k places after the pointer
      cand = rr + k[VBITS-1:0];
      if (active[cand])
      begin
        pick = cand;
        pick_ok = 1'b1;
      end
    end
  end
  // firmware commands and fetch-buffer sequencing
  // one process owns the voice tables so a load and an address advance
  // never fight over the same entry from two drivers
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      // all voices stopped, buffer empty
      active <= {VOICES{1'b0}};
      rr <= {VBITS{1'b0}};
      fb_state <= `WSFP_FB_IDLE;
      cur <= {VBITS{1'b0}};
      fill <= {(BBITS+1){1'b0}};
      blk_ready <= 1'b0;
      rd_addr_out <= {AW{1'b0}};
      rd_len_out <= {(BBITS+1){1'b0}};
    end
    else
    begin
      // parameter load per voice
      // loading a running voice takes effect at its next fetch
      if (cmd_in == `WSFP_CMD_LOAD)
      begin
        v_addr[cmd_voice_in] <= cmd_start_in;
        v_loop[cmd_voice_in] <= cmd_loop_in;
        v_end[cmd_voice_in] <= cmd_end_in;
        v_ratio[cmd_voice_in] <= cmd_ratio_in;
        v_dest[cmd_voice_in] <= cmd_dest_in;
        v_kind[cmd_voice_in] <= cmd_kind_in;
      end
      // start and stop
      // stop only ends future fetches; a block in flight is finished
      if (cmd_in == `WSFP_CMD_START)
        active[cmd_voice_in] <= 1'b1;
      else if (cmd_in == `WSFP_CMD_STOP)
        active[cmd_voice_in] <= 1'b0;
      // processor has emptied the buffer
      if (blk_clear)
        blk_ready <= 1'b0;
      case (fb_state)
        // pick the next voice and set up its read
        `WSFP_FB_IDLE:
        begin
          // buffer must be clear before refilling
          if (pick_ok && !blk_ready && !(cmd_in == `WSFP_CMD_STOP &&
              cmd_voice_in == pick))
          begin
            cur <= pick;
            rd_addr_out <= v_addr[pick];
            rd_len_out <= BLK[BBITS:0];
            rr <= pick + 1'b1;
            fb_state <= `WSFP_FB_REQ;
          end
        end
        `WSFP_FB_REQ:
        begin
          // wait for the bus master to accept the read
          if (rd_gnt_in)
          begin
            fill <= {(BBITS+1){1'b0}};
            fb_state <= `WSFP_FB_DATA;
          end
        end
        // collect one word per valid cycle into the buffer
        `WSFP_FB_DATA:
        begin
          if (rd_valid_in)
          begin
            // the last word of the block hands the buffer over
            buf_mem[fill[BBITS-1:0]] <= rd_data_in;
            fill <= fill + 1'b1;
            if (fill == BLK[BBITS:0] - 1'b1)
            begin
              blk_ready <= 1'b1;
              fb_state <= `WSFP_FB_WAIT;
              // advance and loop voice address
              if (v_addr[cur] + blk_bytes >= v_end[cur])
                v_addr[cur] <= v_loop[cur];
              else
                v_addr[cur] <= v_addr[cur] + blk_bytes;
            end
          end
        end
        // hold off further fetches until the block is consumed
        `WSFP_FB_WAIT:
        begin
          if (blk_clear)
            fb_state <= `WSFP_FB_IDLE;
        end
        // unused code: recover to idle
        default:
          fb_state <= `WSFP_FB_IDLE;
      endcase
    end
  end

  // sample processor: step through the block at the pitch ratio
  // a ratio below unity repeats words (pitch down), above skips them
  // one output word per cycle, so a slow ratio holds the buffer longer
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      // idle, unity step, no write
      sp_state <= `WSFP_SP_IDLE;
      phase <= {PW{1'b0}};
      ratio <= `WSFP_RATIO_UNITY;
      dest <= {MW{1'b0}};
      blk_clear <= 1'b0;
      mem_we_out <= 1'b0;
      mem_addr_out <= {MW{1'b0}};
      mem_data_out <= {DW{1'b0}};
    end
    else
    begin
      // pulses default low
      blk_clear <= 1'b0;
      mem_we_out <= 1'b0;
      case (sp_state)
        // wait for a full block; skip the cycle of our own clear pulse
        `WSFP_SP_IDLE:
        begin
          if (blk_ready && fb_state == `WSFP_FB_WAIT && !blk_clear)
          begin
            // latch the owning voice's step and destination
            phase <= {PW{1'b0}};
            ratio <= (v_ratio[cur] == 16'h0000) ? `WSFP_RATIO_UNITY :
                     v_ratio[cur];
            dest <= v_dest[cur];
            sp_state <= `WSFP_SP_RUN;
          end
        end
        // write one resampled word per cycle
        `WSFP_SP_RUN:
        begin
          // ends when the phase leaves the block
          if (|phase[PW-1:BBITS+`WSFP_FRAC_BITS])
          begin
            // tell the fetch side the buffer is free
            blk_clear <= 1'b1;
            sp_state <= `WSFP_SP_IDLE;
          end
          else
          begin
            // nearest-lower word at the integer part of the phase
            mem_we_out <= 1'b1;
            mem_addr_out <= dest;
            mem_data_out <= buf_mem[phase[BBITS+`WSFP_FRAC_BITS-1:
                                          `WSFP_FRAC_BITS]];
            dest <= dest + 1'b1;
            phase <= phase + {{(PW-16){1'b0}}, ratio};
          end
        end
        // unused code: recover to idle
        default:
          sp_state <= `WSFP_SP_IDLE;
      endcase
    end
  end

  // handshake and status outputs
  // request stands for the whole request state, so it holds until granted
  assign rd_req_out = (fb_state == `WSFP_FB_REQ);
  // per-voice run flags straight from the register
  assign voice_active_out = active;
  // busy while either side holds the buffer
  assign busy_out = (fb_state != `WSFP_FB_IDLE) || sp_state;
endmodule

// ### rtl/wsfp_map.vh
// constants for the wavetable sample fetch path
`ifndef WSFP_MAP_VH
`define WSFP_MAP_VH
// voice command codes from firmware
`define WSFP_CMD_NONE 2'h0
`define WSFP_CMD_START 2'h1
`define WSFP_CMD_STOP 2'h2
`define WSFP_CMD_LOAD 2'h3
// voice source kinds
`define WSFP_SRC_STREAM 1'h0
`define WSFP_SRC_WAVE 1'h1
// fetch-buffer states
`define WSFP_FB_IDLE 2'h0
`define WSFP_FB_REQ 2'h1
`define WSFP_FB_DATA 2'h2
`define WSFP_FB_WAIT 2'h3
// sample processor states
`define WSFP_SP_IDLE 1'h0
`define WSFP_SP_RUN 1'h1
// pitch ratio: fraction bit count and the unity step
`define WSFP_FRAC_BITS 8
`define WSFP_RATIO_UNITY 16'h0100
`endif

// ### sim/wsfp_fetch_path_assertions.sv
// port-level checks for the fetch path
`timescale 1ns/1ns
`include "wsfp_map.vh"
module wsfp_fetch_path_assertions
#(
  parameter VOICES = 64,
  parameter VBITS = 6,
  parameter AW = 32,
  parameter BLK = 16,
  parameter BBITS = 4,
  parameter DW = 16,
  parameter MW = 16
)
(
  // everything is watched, nothing driven
  input wire clk_in,
  input wire rst_in,
  input wire [1:0] cmd_in,
  input wire [VBITS-1:0] cmd_voice_in,
  input wire rd_req_out,
  input wire [AW-1:0] rd_addr_out,
  input wire [BBITS:0] rd_len_out,
  input wire rd_gnt_in,
  input wire rd_valid_in,
  input wire mem_we_out,
  input wire [VOICES-1:0] voice_active_out,
  input wire busy_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // final word of a block then a gap
  sequence s_last_word;
    rd_valid_in ##1 !rd_valid_in;
  endsequence
  a_req_holds: assert property (rd_req_out && !rd_gnt_in |=> rd_req_out)
    else $error("request withdrawn before grant");
  a_addr_holds: assert property (rd_req_out && !rd_gnt_in |=> $stable(rd_addr_out))
    else $error("request address moved before grant");
  a_block_len: assert property (rd_req_out |-> rd_len_out == BLK)
    else $error("request length is not one block");
  a_no_refill: assert property (rd_req_out && rd_gnt_in |=> !rd_req_out [*8])
    else $error("refill requested before block clear");
  a_proc_start: assert property (s_last_word |-> ##2 mem_we_out)
    else $error("processing did not start after data");
  a_write_busy: assert property (mem_we_out |-> busy_out && !rd_req_out)
    else $error("request raised while block in use");
  a_start_act: assert property (cmd_in == `WSFP_CMD_START |=>
    voice_active_out[$past(cmd_voice_in)]) else $error("start did not activate voice");
  a_stop_act: assert property (cmd_in == `WSFP_CMD_STOP |=>
    !voice_active_out[$past(cmd_voice_in)]) else $error("stop left voice active");
  a_idle_quiet: assert property (voice_active_out == 0 && !busy_out |=> !rd_req_out)
    else $error("request with no active voice");
endmodule
bind wsfp_fetch_path wsfp_fetch_path_assertions #(.VOICES(VOICES), .VBITS(VBITS), .AW(AW),
  .BLK(BLK),
  .BBITS(BBITS), .DW(DW), .MW(MW)) wsfp_fetch_path_assertions_inst (.*);

// ### sim/wsfp_bus_model.sv
// bus-master read partner: grants late or early, returns one block
`timescale 1ns/1ns
module wsfp_bus_model
(
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // request side
  input wire req_in,
  input wire [4:0] len_in,
  input wire slow_in,
  // answer side
  output reg gnt_out,
  output reg valid_out,
  output reg [15:0] data_out
);
  reg [4:0] left; // words still owed
  reg [3:0] dly; // cycles spent waiting
  // data line churns whenever no word is valid
  always @(posedge clk_in)
  begin
    gnt_out <= 1'b0;
    valid_out <= 1'b0;
    data_out <= ~data_out;
    if (rst_in)
    begin
      left <= 5'h00;
      dly <= 4'h0;
      data_out <= 16'h0000;
    end
    else if (left != 5'h00)
    begin
      valid_out <= 1'b1;
      data_out <= {11'h5A3, left};
      left <= left - 5'h01;
    end
    else if (req_in)
    begin
      dly <= dly + 4'h1;
      if (dly == {1'b0, slow_in, slow_in, slow_in})
      begin
        gnt_out <= 1'b1;
        left <= len_in;
        dly <= 4'h0;
      end
    end
  end
endmodule

// ### sim/wsfp_fetch_path_tb.sv
// self-checking bench for the fetch path
`timescale 1ns/1ns
`include "wsfp_map.vh"
module wsfp_fetch_path_tb;
  reg clk_in, rst_in, cmd_kind_in, slow;
  reg [1:0] cmd_in;
  reg [5:0] cmd_voice_in;
  reg [31:0] cmd_start_in, cmd_loop_in, cmd_end_in, lf;
  reg [15:0] cmd_ratio_in, cmd_dest_in;
  wire rd_req_out, rd_gnt_in, rd_valid_in, mem_we_out, busy_out;
  wire [31:0] rd_addr_out;
  wire [4:0] rd_len_out;
  wire [15:0] rd_data_in, mem_addr_out, mem_data_out;
  wire [63:0] voice_active_out;
  integer err_count, cmp_count, i, n, t;
  wsfp_fetch_path wsfp_fetch_path_inst (.*);
  wsfp_bus_model wsfp_bus_model_inst (.clk_in(clk_in), .rst_in(rst_in), .req_in(rd_req_out),
    .len_in(rd_len_out), .slow_in(slow), .gnt_out(rd_gnt_in), .valid_out(rd_valid_in),
    .data_out(rd_data_in));
  // lfsr step and expected write count per block
  function [31:0] nx(input [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [31:0] nwr(input [15:0] r);
    nwr = (4096 + r - 1) / r;
  endfunction
  task chk(input [8*5:1] nm, input [31:0] e, input [31:0] g);
  begin
    cmp_count = cmp_count + 1;
    if (e !== g)
    begin
      err_count = err_count + 1;
      $display("MISMATCH %0s exp %h got %h", nm, e, g);
    end
  end
  endtask
  task conclude;
  begin
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  // one-cycle command pulse
  task cmd(input [1:0] c);
  begin
    @(posedge clk_in);
    cmd_in <= c;
    @(posedge clk_in);
    cmd_in <= `WSFP_CMD_NONE;
  end
  endtask
  // await request, check it, count writes until the next one
  task blk(input [7:0] a);
  begin
    for (t = 0; t < 200 && rd_req_out !== 1'b1; t = t + 1)
      @(negedge clk_in);
    chk("req", 1, rd_req_out);
    if (t == 200)
      conclude;
    chk("addr", {cmd_start_in[31:8], a}, rd_addr_out);
    n = 0;
    for (t = 0; t < 90 && (n == 0 || rd_req_out !== 1'b1); t = t + 1)
    begin
      @(negedge clk_in);
      if (mem_we_out === 1'b1 && n == 0)
      begin
        chk("dest", cmd_dest_in, mem_addr_out);
        chk("data", {11'h5A3, 5'h10}, mem_data_out);
      end
      n = n + (mem_we_out === 1'b1);
    end
    chk("words", nwr(cmd_ratio_in), n);
    chk("next", 1, rd_req_out);
    if (rd_req_out !== 1'b1)
      conclude;
  end
  endtask
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial
  begin
    err_count = 0;
    cmp_count = 0;
    lf = 43;
    {rst_in, cmd_kind_in, slow, cmd_in, cmd_voice_in} = 11'h400;
    {cmd_start_in, cmd_loop_in, cmd_end_in, cmd_ratio_in, cmd_dest_in} = 0;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    for (i = 0; i < 3; i = i + 1)
    begin
      lf = nx(lf);
      {cmd_voice_in, cmd_kind_in, slow} <= lf[7:0];
      cmd_start_in <= {lf[31:8], 8'h00};
      cmd_loop_in <= {lf[31:8], 8'h10};
      cmd_end_in <= {lf[31:8], 8'h60};
      cmd_dest_in <= lf[23:8];
      cmd_ratio_in <= 16'h0080 << i;
      cmd(`WSFP_CMD_LOAD);
      cmd(`WSFP_CMD_START);
      blk(8'h00);
      blk(8'h20);
      blk(8'h40);
      blk(8'h10);
      cmd(`WSFP_CMD_STOP);
      repeat (100) @(negedge clk_in);
      chk("act", 0, voice_active_out[cmd_voice_in]);
      chk("busy", 0, busy_out);
      n = 0;
      repeat (20) @(negedge clk_in) n = n + rd_req_out;
      chk("quiet", 0, n);
    end
    conclude;
  end
endmodule
